// ### dsrx_pkg.sv
// dsrx_pkg: constants and carriers for the three lane deserializer
// assumes a 25 MHz system clock and pins sampled in that domain
package dsrx_pkg;

  localparam int LANES          = 3;
  localparam int LANE_BITS      = 7;
  localparam int WORD_W         = LANES * LANE_BITS;
  localparam int SYNC_W         = 2 * (LANES + 1) + 1;
  localparam int CNT_W          = 8;
  localparam int ACC_W          = CNT_W + 1;
  localparam int LOCK_W         = 16;

  localparam int CLK_MHZ        = 25;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int T_LOCK_US      = 1000;
  localparam int LOCK_CYC       = T_LOCK_US * CLK_MHZ;
  localparam int T_OFF_NS       = 400;
  localparam int OFF_CYC        = T_OFF_NS / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;
  localparam logic [ACC_W-1:0] ACC_STEP = 9'h007;
  localparam logic [3:0]       BIT_LAST = 4'h7;

  typedef struct packed {
    logic [LANES-1:0] pos;
    logic [LANES-1:0] neg;
  } dsrx_lanes_s;

  typedef logic [LANE_BITS-1:0] dsrx_lane_t;

endpackage

// ### dsrx_sync.sv
// dsrx_sync: two flop synchroniser for a group of pin levels
// assumes levels arrive asynchronous to clk_sys_i
`timescale 1ns/100ps
module dsrx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // dsrx_sync

// ### dsrx_deser.sv
// dsrx_deser: three lane 7:1 deserializer with word clock and shutdown
// assumes lanes and link clock are pins outside the clk_sys_i domain
// Operation
// - three 7-bit lane shift registers, 21-bit word
// - shift each lane at seven bits per link period
// - transfer all lanes once per link period
// - derive bit timing and word clock from link
// - word valid at word clock rising edge
// - shutdown low stops clocking, disables receivers
// - shutdown low clears every register except the pin synchroniser to zero
// - output valid only after lock time elapses
// - off state reached within 400 ns
`timescale 1ns/100ps
module dsrx_deser
  import dsrx_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire dsrx_lanes_s       lanes_i,
  input  wire logic              link_clock_pos_i,
  input  wire logic              link_clock_neg_i,
  input  wire logic              shutdown_clear_n_i,
  output logic      [WORD_W-1:0] parallel_out_o,
  output logic                   word_clock_out_o,
  output logic                   locked_o
);

  logic [SYNC_W-1:0] pins_s;
  logic [LANES-1:0]  pos_s;
  logic [LANES-1:0]  neg_s;
  logic              clkp_s;
  logic              clkn_s;
  logic              shdn_n_s;
  logic [LANES-1:0]  rx_bit;
  logic              rx_clk;
  logic              link_edge;

  dsrx_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .d_i       ({shutdown_clear_n_i, link_clock_pos_i, link_clock_neg_i,
                 lanes_i.pos, lanes_i.neg}),
    .q_o       (pins_s)
  );

  assign {shdn_n_s, clkp_s, clkn_s, pos_s, neg_s} = pins_s;

  // receivers off while shut down
  assign rx_bit = pos_s & ~neg_s & {LANES{shdn_n_s}};
  assign rx_clk = clkp_s & ~clkn_s & shdn_n_s;

  logic                           clk_prev_q, clk_prev_d;
  logic [CNT_W-1:0]               per_cnt_q, per_cnt_d;
  logic [CNT_W-1:0]               period_q, period_d;
  logic [ACC_W-1:0]               acc_q, acc_d;
  logic [3:0]                     bitcnt_q, bitcnt_d;
  logic [LANES-1:0][LANE_BITS-1:0] shift_q, shift_d;
  logic [WORD_W-1:0]              out_q, out_d;
  logic                           wclk_q, wclk_d;
  logic [LOCK_W-1:0]              lock_cnt_q, lock_cnt_d;
  logic                           locked_q, locked_d;
  logic [ACC_W-1:0]               acc_sum;
  logic                           bit_tick;

  assign link_edge = rx_clk & ~clk_prev_q;
  assign acc_sum   = acc_q + ACC_STEP;
  // six more evenly spread bit strobes after the edge slot
  assign bit_tick  = shdn_n_s & ~link_edge & (acc_sum >= {1'b0, period_q})
                     & (bitcnt_q < BIT_LAST);

  always_comb begin
    clk_prev_d = rx_clk;
    per_cnt_d  = per_cnt_q;
    period_d   = period_q;
    acc_d      = acc_q;
    bitcnt_d   = bitcnt_q;
    shift_d    = shift_q;
    out_d      = out_q;
    wclk_d     = wclk_q;
    lock_cnt_d = lock_cnt_q;
    locked_d   = locked_q;
    if (!shdn_n_s) begin
      // clear everything, stop clocking
      clk_prev_d = 1'b0;
      per_cnt_d  = CNT_RST;
      period_d   = CNT_RST;
      acc_d      = '0;
      bitcnt_d   = '0;
      shift_d    = '0;
      out_d      = '0;
      wclk_d     = 1'b0;
      lock_cnt_d = '0;
      locked_d   = 1'b0;
    end else begin
      // lock time after release
      if (!locked_q) begin
        lock_cnt_d = lock_cnt_q + 16'h0001;
        if (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1)) begin
          locked_d = 1'b1;
        end
      end
      if (link_edge) begin
        period_d  = per_cnt_q + 8'h01;
        per_cnt_d = CNT_RST;
        // first slot arrives with the edge; later strobes sit a quarter period in
        acc_d     = ACC_W'(period_d[CNT_W-1:2]);
        bitcnt_d  = 4'h1;
        wclk_d    = 1'b0;
        for (int l = 0; l < LANES; l++) begin
          shift_d[l] = {shift_q[l][LANE_BITS-2:0], rx_bit[l]};
        end
        if (locked_q) begin
          out_d = {shift_q[2], shift_q[1], shift_q[0]};
        end
      end else begin
        if (per_cnt_q != CNT_MAX) begin
          per_cnt_d = per_cnt_q + 8'h01;
        end
        if (bit_tick) begin
          acc_d    = acc_sum - {1'b0, period_q};
          bitcnt_d = bitcnt_q + 4'h1;
          for (int l = 0; l < LANES; l++) begin
            shift_d[l] = {shift_q[l][LANE_BITS-2:0], rx_bit[l]};
          end
        end else if (acc_sum <= {1'b0, period_q}) begin
          acc_d = acc_sum;
        end
        // rise mid period, data settled since the edge
        if (locked_q && per_cnt_q == {1'b0, period_q[CNT_W-1:1]}) begin
          wclk_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      clk_prev_q <= 1'b0;
      per_cnt_q  <= CNT_RST;
      period_q   <= CNT_RST;
      acc_q      <= '0;
      bitcnt_q   <= '0;
      shift_q    <= '0;
      out_q      <= '0;
      wclk_q     <= 1'b0;
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      per_cnt_q  <= per_cnt_d;
      period_q   <= period_d;
      acc_q      <= acc_d;
      bitcnt_q   <= bitcnt_d;
      shift_q    <= shift_d;
      out_q      <= out_d;
      wclk_q     <= wclk_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q   <= locked_d;
    end
  end

  assign parallel_out_o   = out_q;
  assign word_clock_out_o = wclk_q;
  assign locked_o         = locked_q;

  localparam int OFF_LIM = OFF_CYC;

  sequence edge_locked_seq;
    link_edge && locked_q && shdn_n_s;
  endsequence

  sequence shut_seq;
    !shdn_n_s;
  endsequence

  clear_regs_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    shut_seq |=> (out_q == '0) && (shift_q == '0) && !wclk_q && !locked_q)
    else $error("registers not cleared in shutdown");

  rx_off_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    shut_seq |-> (rx_bit == '0) && !rx_clk && !bit_tick)
    else $error("receivers active in shutdown");

  off_time_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(shutdown_clear_n_i) |-> ##[1:OFF_LIM] (!word_clock_out_o && !locked_o))
    else $error("off state not reached in time");

  word_xfer_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    edge_locked_seq |=> parallel_out_o == $past({shift_q[2], shift_q[1], shift_q[0]}))
    else $error("word not transferred on link edge");

  lane_shift_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bit_tick || link_edge) |=> shift_q[0] == {$past(shift_q[0][5:0]), $past(rx_bit[0])})
    else $error("lane shift wrong");

  bit_count_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bitcnt_q <= BIT_LAST)
    else $error("more than seven bits per word");

  word_stable_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(word_clock_out_o) |-> $stable(parallel_out_o) && locked_o)
    else $error("data changed at word clock rise");

  lock_wait_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(locked_o) |-> $past(lock_cnt_q) == LOCK_W'(LOCK_CYCLES - 1))
    else $error("lock asserted early");

  unlocked_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !locked_o |-> !word_clock_out_o ##1 (locked_o || $stable(parallel_out_o)))
    else $error("output active before lock");

endmodule // dsrx_deser

// ### dsrx_tx_model.sv
// dsrx_tx_model: serializing transmitter, three lanes plus link clock
// assumes the bench holds word_i steady for whole frames while en_i is high
`timescale 1ns/100ps
module dsrx_tx_model
  import dsrx_pkg::*;
(
  input  wire logic              en_i,
  input  wire logic [WORD_W-1:0] word_i,
  output dsrx_lanes_s            lanes_o,
  output logic                   clk_p_o,
  output logic                   clk_n_o
);
  localparam int SLOT_NS = 45;
  logic [LANES-1:0] bits;
  assign lanes_o = '{pos: bits, neg: ~bits};
  assign clk_n_o = ~clk_p_o;
  initial begin
    bits = '0;
    clk_p_o = 1'b0;
    #7;
    forever begin
      if (en_i) begin
        // 320 ns frame, slower than the 31 to 68 MHz band
        clk_p_o = 1'b1;
        for (int s = 0; s < LANE_BITS; s++) begin
          for (int k = 0; k < LANES; k++)
            bits[k] = word_i[k*LANE_BITS+6-s];
          if (s == 4)
            clk_p_o = 1'b0;
          #SLOT_NS;
        end
        #5;
      end else begin
        // idle: clock still, lanes keep changing
        clk_p_o = 1'b0;
        bits = ~bits;
        #40;
      end
    end
  end
endmodule // dsrx_tx_model

// ### tb_top.sv
// tb_top: self-checking bench for dsrx_deser
// assumes dsrx_tx_model as far side, lock time cut to 20 cycles
`timescale 1ns/100ps
module tb_top
  import dsrx_pkg::*;
;
  localparam int LOCK_TB = 20;
  logic              clk = 1'b0;
  logic              srst;
  logic              sd_n;
  logic              tx_en;
  logic [WORD_W-1:0] tx_word;
  logic [WORD_W-1:0] pout;
  logic              lk_p;
  logic              lk_n;
  logic              wclk;
  logic              locked;
  dsrx_lanes_s       lanes;
  int                err_total;
  int                tests_run;
  always #20 clk = ~clk;
  dsrx_tx_model dsrx_tx_model_i (.en_i(tx_en), .word_i(tx_word), .lanes_o(lanes),
    .clk_p_o(lk_p), .clk_n_o(lk_n));
  dsrx_deser #(.LOCK_CYCLES(LOCK_TB)) dsrx_deser_i (.clk_sys_i(clk), .srst_i(srst),
    .lanes_i(lanes), .link_clock_pos_i(lk_p), .link_clock_neg_i(lk_n),
    .shutdown_clear_n_i(sd_n), .parallel_out_o(pout), .word_clock_out_o(wclk),
    .locked_o(locked));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_word(string nm, logic [WORD_W-1:0] e, logic [WORD_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic wait_wclk(logic v);
    int n;
    n = 0;
    while (wclk !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40)
      chk_flag("word clock wait", v, wclk);
  endtask
  task automatic t_data(logic [WORD_W-1:0] w);
    tx_word = w;
    repeat (4) begin
      wait_wclk(1'b0);
      wait_wclk(1'b1);
    end
    chk_word("word at rise", w, pout);
  endtask
  task automatic t_rate();
    int n;
    logic p;
    n = 0;
    p = wclk;
    repeat (80) begin
      @(negedge clk);
      if (wclk === 1'b1 && p === 1'b0)
        n++;
      p = wclk;
    end
    chk_flag("one rise per period", 1'b1, n == 10);
  endtask
  task automatic t_shut();
    int n;
    sd_n = 1'b0;
    repeat (OFF_CYC) @(negedge clk);
    chk_word("out after shutdown", '0, pout);
    chk_flag("wclk after shutdown", 1'b0, wclk);
    repeat (20) @(negedge clk);
    chk_word("out held clear", '0, pout);
    chk_flag("lock held clear", 1'b0, locked);
    sd_n = 1'b1;
    n = 0;
    while (locked !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk_flag("lock time", 1'b1, n >= LOCK_TB && n <= LOCK_TB + 4);
  endtask
  initial begin
    srst = 1'b1;
    sd_n = 1'b1;
    tx_en = 1'b0;
    tx_word = '0;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    chk_word("reset out", '0, pout);
    chk_flag("reset lock", 1'b0, locked);
    tx_en = 1'b1;
    t_data(21'h1A5F3C);
    t_data(21'h1FFFFF);
    t_data(21'h000000);
    t_data(21'h0AA955);
    t_rate();
    t_shut();
    t_data(21'h15566A);
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule // tb_top
